// File: bench/dira_receive_monitor.sv
`timescale 1ns/1ps
// port checks; masks are shadowed from the register writes
module dira_monitor #(
  parameter CW = 16
) (
  input logic          core_clk,
  input logic          reset,
  input logic          codeValid,
  input logic [1:0]    codeKind,
  input logic [5:0]    codeNum,
  input logic          sentValid,
  input logic [5:0]    sentNum,
  input logic          extendedModeSelect,
  input logic          acceptAnyAck,
  input logic          rxCodeIrqEnable,
  input logic          rxAckIrqEnable,
  input logic          timeoutIrqEnable,
  input logic          portIrqEnable,
  input logic [CW-1:0] timeoutPeriodTimer,
  input logic          regSel,
  input logic          regWrite,
  input logic [7:0]    regAddr,
  input logic [31:0]   regWdata,
  input logic          regReady,
  input logic          irqPulse
);
  logic [31:0] maskLo_q;
  logic [31:0] maskHi_q;
  // decoded code offers, and whether a timeout may also pulse
  wire lo  = maskLo_q[codeNum[4:0]];
  wire hi  = maskHi_q[codeNum[4:0]];
  wire tmo = timeoutIrqEnable && portIrqEnable;
  wire cv0 = codeValid && codeKind == 2'h0 && !codeNum[5];
  wire cv1 = codeValid && codeKind == 2'h1 && !codeNum[5];
  wire cv2 = codeValid && codeKind == 2'h2;
  // bank follows the mode bit at write time, as in the port
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      maskLo_q <= 32'h0;
      maskHi_q <= 32'h0;
    end else if (regSel && regWrite && regAddr == 8'hB0) begin
      if (extendedModeSelect) maskHi_q <= regWdata;
      else maskLo_q <= regWdata;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_ready_follows: assert property (regSel |=> regReady) else $error("no ready");
  a_code_irq: assert property (cv0 && lo && rxCodeIrqEnable |=> irqPulse)
    else $error("code irq");
  a_code_masked: assert property (cv0 && !lo && !tmo |=> !irqPulse)
    else $error("masked code");
  a_ack_irq: assert property (cv1 && !extendedModeSelect && acceptAnyAck && lo
    && rxAckIrqEnable |=> irqPulse) else $error("ack irq");
  a_ack_masked: assert property (cv1 && !lo && !tmo |=> !irqPulse)
    else $error("masked ack");
  a_ext_irq: assert property (cv2 && codeNum[5] && extendedModeSelect && hi
    && rxAckIrqEnable |=> irqPulse) else $error("ext irq");
  a_ext_masked: assert property (cv2 && !hi && !tmo |=> !irqPulse)
    else $error("masked ext");
  a_timeout_irq: assert property (sentValid && timeoutPeriodTimer == 16'h0003
    && !sentNum[5] && maskLo_q[sentNum[4:0]] && tmo
    ##1 (!codeValid && !sentValid && !regSel && tmo) [*4] |=> irqPulse)
    else $error("timeout irq");
  a_timeout_quiet: assert property (sentValid && !tmo
    ##1 (!codeValid && !sentValid && !regSel && !tmo) [*4] |=> !irqPulse)
    else $error("timeout irq not gated");
endmodule // dira_monitor

bind dira_receive dira_monitor #(.CW(CW)) mon (
  .core_clk(core_clk), .reset(reset), .codeValid(codeValid), .codeKind(codeKind),
  .codeNum(codeNum), .sentValid(sentValid), .sentNum(sentNum),
  .extendedModeSelect(extendedModeSelect), .acceptAnyAck(acceptAnyAck),
  .rxCodeIrqEnable(rxCodeIrqEnable), .rxAckIrqEnable(rxAckIrqEnable),
  .timeoutIrqEnable(timeoutIrqEnable), .portIrqEnable(portIrqEnable),
  .timeoutPeriodTimer(timeoutPeriodTimer), .regSel(regSel), .regWrite(regWrite),
  .regAddr(regAddr), .regWdata(regWdata), .regReady(regReady), .irqPulse(irqPulse));

// File: bench/dira_switch_model.sv
`timescale 1ns/1ps
// switch matrix side: one code offered per call
module dira_switch_model (
  input  logic       core_clk,
  output logic       codeValid = 1'b0,
  output logic [1:0] codeKind  = 2'h3,
  output logic [5:0] codeNum   = 6'h3F
);
  // idle fields carry the inverse so a stale code never looks offered
  task automatic send(input logic [1:0] k, input logic [5:0] n);
    @(posedge core_clk) #1;
    {codeValid, codeKind, codeNum} = {1'b1, k, n};
    @(posedge core_clk) #1;
    {codeValid, codeKind, codeNum} = {1'b0, ~k, ~n};
  endtask
endmodule // dira_switch_model

// File: bench/tb_distributed_interrupt_receive.sv
`timescale 1ns/1ps
// register-level tests of the receive flags behind the switch model
module tb_distributed_interrupt_receive;
  logic core_clk = 0, reset = 1, sentValid = 0, regSel = 0, regWrite = 0;
  logic extendedModeSelect = 0, acceptAnyAck = 0, rxCodeIrqEnable = 1;
  logic rxAckIrqEnable = 1, timeoutIrqEnable = 0, portIrqEnable = 1;
  logic [5:0]  sentNum = 6'h00;
  logic [15:0] timeoutPeriodTimer = 16'h0000;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic [7:0]  ra[5] = '{8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'h00};
  wire         codeValid, regReady, irqPulse;
  wire [1:0]   codeKind;
  wire [5:0]   codeNum;
  wire [31:0]  regRdata;
  int          fails = 0, compares = 0;
  always #2 core_clk = ~core_clk;
  dira_switch_model sw (
    .core_clk(core_clk), .codeValid(codeValid), .codeKind(codeKind), .codeNum(codeNum));
  dira_receive dut (
    .core_clk(core_clk), .reset(reset), .codeValid(codeValid), .codeKind(codeKind),
    .codeNum(codeNum), .sentValid(sentValid), .sentNum(sentNum),
    .extendedModeSelect(extendedModeSelect), .acceptAnyAck(acceptAnyAck),
    .rxCodeIrqEnable(rxCodeIrqEnable), .rxAckIrqEnable(rxAckIrqEnable),
    .timeoutIrqEnable(timeoutIrqEnable), .portIrqEnable(portIrqEnable),
    .timeoutPeriodTimer(timeoutPeriodTimer), .regSel(regSel), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regReady(regReady),
    .irqPulse(irqPulse));
  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask
  // one strobe cycle; the answer is taken at the following edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk) #1;
    {regSel, regWrite, regAddr, regWdata} = {1'b1, w, a, d};
    @(posedge core_clk) #1;
    regSel = 0;
    chk({31'h0, regReady}, 32'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(regRdata, e);
  endtask
  // software send: starts the watchdog for that number
  task automatic snd(input logic [5:0] n, input logic [15:0] p);
    @(posedge core_clk) #1;
    {sentValid, sentNum, timeoutPeriodTimer} = {1'b1, n, p};
    @(posedge core_clk) #1;
    sentValid = 0;
  endtask
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 reset = 0;
    // both banks and an unmapped offset read zero
    for (int m = 1; m >= 0; m--) begin
      extendedModeSelect = m[0];
      foreach (ra[i]) rd(ra[i], 32'h0);
    end
    acc(1'b1, 8'hB0, 32'h000000FF);
    sw.send(2'h0, 6'h03);
    sw.send(2'h0, 6'h09);
    sw.send(2'h0, 6'h03);
    chk({31'h0, irqPulse}, 32'h1);
    rd(8'hA4, 32'h8);
    acc(1'b1, 8'hA4, 32'h0);
    rd(8'hA4, 32'h8);
    acc(1'b1, 8'hA4, 32'h8);
    rd(8'hA4, 32'h0);
    // ack 2 taken through any-ack, 4 never sent, 5 matches a send
    acceptAnyAck = 1;
    sw.send(2'h1, 6'h02);
    sw.send(2'h1, 6'h09);
    acceptAnyAck = 0;
    sw.send(2'h1, 6'h04);
    snd(6'h05, 16'h0014);
    sw.send(2'h1, 6'h05);
    rd(8'hA8, 32'h24);
    timeoutIrqEnable = 1;
    snd(6'h06, 16'h0003);
    repeat (30) @(posedge core_clk);
    rd(8'hAC, 32'h40);
    // port enable off: the flag still sets, the pulse must stay quiet
    portIrqEnable = 0;
    snd(6'h07, 16'h0003);
    repeat (8) @(posedge core_clk);
    rd(8'hAC, 32'hC0);
    acc(1'b1, 8'hAC, 32'hC0);
    rd(8'hAC, 32'h0);
    portIrqEnable = 1;
    timeoutIrqEnable = 0;
    extendedModeSelect = 1;
    acc(1'b1, 8'hB0, 32'h1);
    sw.send(2'h2, 6'h20);
    sw.send(2'h2, 6'h21);
    rd(8'hA8, 32'h25);
    snd(6'h20, 16'h0002);
    repeat (6) @(posedge core_clk);
    rd(8'hAC, 32'h1);
    acc(1'b1, 8'hAC, 32'h1);
    rd(8'hAC, 32'h0);
    rd(8'hB0, 32'h1);
    extendedModeSelect = 0;
    rd(8'hB0, 32'hFF);
    acc(1'b1, 8'hA8, 32'h24);
    rd(8'hA8, 32'h1);
    end_sim;
  end
  // hang guard: the sequence needs about 150 cycles
  initial begin
    #20000;
    fails++;
    end_sim;
  end
endmodule // tb_distributed_interrupt_receive

// File: design/dira_code_timer.v
`timescale 1ns/1ps
`include "dira_map.vh"
// per-interrupt watchdog on codes sent by software; one counter per number
module dira_code_timer #(
  parameter NUM = 64,
  parameter CW  = `DIRA_PERIOD_WIDTH
) (
  input  wire            core_clk,
  input  wire            reset,
  input  wire            sendValid,
  input  wire [5:0]      sendNum,
  input  wire [NUM-1:0]  ackClear,
  input  wire [CW-1:0]   timeoutPeriod,
  output reg  [NUM-1:0]  pendingVec,
  output reg  [NUM-1:0]  expireVec
);

  reg [CW-1:0] count [0:NUM-1];
  integer      i;

  // a fresh send restarts the wait; an ack ends it; expiry is a one-cycle pulse
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pendingVec <= {NUM{1'b0}};
      expireVec  <= {NUM{1'b0}};
      for (i = 0; i < NUM; i = i + 1) begin
        count[i] <= {CW{1'b0}};
      end
    end else begin
      for (i = 0; i < NUM; i = i + 1) begin
        expireVec[i] <= 1'b0;
        if (sendValid && (sendNum == i[5:0])) begin
          pendingVec[i] <= 1'b1;
          count[i]      <= timeoutPeriod;
        end else if (ackClear[i]) begin
          pendingVec[i] <= 1'b0;
        end else if (pendingVec[i]) begin
          // a period of zero or one expires on the next edge
          if (count[i] <= {{(CW-1){1'b0}}, 1'b1}) begin
            pendingVec[i] <= 1'b0;
            expireVec[i]  <= 1'b1;
          end else begin
            count[i] <= count[i] - {{(CW-1){1'b0}}, 1'b1};
          end
        end
      end
    end
  end

endmodule // dira_code_timer

// File: design/dira_map.vh
`ifndef DIRA_MAP_VH
`define DIRA_MAP_VH

// register byte offsets
`define DIRA_OFS_RXCODE      8'hA4
`define DIRA_OFS_ACKEXT      8'hA8
`define DIRA_OFS_TIMEOUT     8'hAC
`define DIRA_OFS_MASK        8'hB0

// reset values
`define DIRA_RST_FLAGS       32'h00000000
`define DIRA_RST_MASK        32'h00000000

// kinds of distributed interrupt code arriving from the switch matrix
`define DIRA_KIND_INTR       2'h0
`define DIRA_KIND_ACK        2'h1
`define DIRA_KIND_EXT        2'h2

// code number layout: bit 5 selects the upper bank (numbers 32-63)
`define DIRA_NUM_BANK_BIT    5
`define DIRA_NUM_IDX_MSB     4

// default width of the timeout period count
`define DIRA_PERIOD_WIDTH    16

`endif

// File: design/dira_receive.v
`timescale 1ns/1ps
`include "dira_map.vh"

// Function
// - An accepted interrupt code n below 32 sets bit n of the received-code flags.
// - In extended mode an extended code n+32 with high mask bit n set sets ack/ext bit n.
// - In ack mode an ack code n with low mask bit n set sets ack/ext bit n if any-ack or sent.
// - A sent code n below 32 left unacknowledged for the period sets low timeout bit n when unmasked.
// - A sent extended code n+32 that times out sets high timeout bit n when unmasked.
// - Interrupt and ack codes for n are dropped while low mask bit n is zero.
// - Extended codes for n+32 are dropped while high mask bit n is zero.
// - With the code irq enable, each received-code flag set raises an interrupt.
// - With the ack irq enable, each ack/ext flag set raises an interrupt.
// - With timeout and port irq enables, any timeout flag set raises an interrupt.
module dira_receive #(
  parameter CW = `DIRA_PERIOD_WIDTH
) (
  input  wire          core_clk,
  input  wire          reset,
  // codes from the switch matrix, same clock
  input  wire          codeValid,
  input  wire [1:0]    codeKind,
  input  wire [5:0]    codeNum,
  // codes software sent towards the switch matrix
  input  wire          sentValid,
  input  wire [5:0]    sentNum,
  // control bits held in the port control and router config registers
  input  wire          extendedModeSelect,
  input  wire          acceptAnyAck,
  input  wire          rxCodeIrqEnable,
  input  wire          rxAckIrqEnable,
  input  wire          timeoutIrqEnable,
  input  wire          portIrqEnable,
  input  wire [CW-1:0] timeoutPeriodTimer,
  // register port
  input  wire          regSel,
  input  wire          regWrite,
  input  wire [7:0]    regAddr,
  input  wire [31:0]   regWdata,
  output reg  [31:0]   regRdata,
  output reg           regReady,
  // processor interrupt request, high one cycle for each cycle with an event whose irq enable is set; timeouts also need the port irq enable
  output reg           irqPulse
);

  reg  [31:0] receivedCodeBits_q;
  reg  [31:0] receivedCodeBits_d;
  reg  [31:0] ackOrExtReceivedBits_q;
  reg  [31:0] ackOrExtReceivedBits_d;
  reg  [31:0] codeTimeoutLow_q;
  reg  [31:0] codeTimeoutLow_d;
  reg  [31:0] codeTimeoutHigh_q;
  reg  [31:0] codeTimeoutHigh_d;
  reg  [31:0] acceptMaskLow_q;
  reg  [31:0] acceptMaskHigh_q;
  reg  [31:0] rdata_d;
  reg         irq_d;

  wire [63:0] pendingVec;
  wire [63:0] expireVec;
  wire [63:0] ackClear;

  // one-hot of the low five bits of a code number
  // a function since the set vectors and both mask tests share it
  function [31:0] numOneHot;
    input [5:0] num;
    begin
      numOneHot = 32'h00000001 << num[`DIRA_NUM_IDX_MSB:0];
    end
  endfunction

  // register decode
  wire        wrAccess  = regSel && regWrite;
  wire        rdAccess  = regSel && !regWrite;
  wire        hitRxCode = (regAddr == `DIRA_OFS_RXCODE);
  wire        hitAckExt = (regAddr == `DIRA_OFS_ACKEXT);
  wire        hitTmo    = (regAddr == `DIRA_OFS_TIMEOUT);
  wire        hitMask   = (regAddr == `DIRA_OFS_MASK);

  // incoming code classification
  wire        codeHigh  = codeNum[`DIRA_NUM_BANK_BIT];
  wire [31:0] codeHot   = numOneHot(codeNum);
  wire        lowMaskOk = |(codeHot & acceptMaskLow_q);
  wire        highMaskOk = |(codeHot & acceptMaskHigh_q);
  // an ack arriving after expiry finds no pending watchdog and is not matched
  wire        sentMatch = pendingVec[codeNum];

  // interrupt code n: low bank only, gated by low mask
  wire        intrHit   = codeValid && (codeKind == `DIRA_KIND_INTR) && !codeHigh
                          && lowMaskOk;
  // extended code n+32: extended mode, high bank, gated by high mask
  wire        extHit    = codeValid && (codeKind == `DIRA_KIND_EXT) && extendedModeSelect
                          && codeHigh && highMaskOk;
  // ack code n: ack mode, gated by low mask and by the sent-or-any test
  wire        ackHit    = codeValid && (codeKind == `DIRA_KIND_ACK) && !extendedModeSelect
                          && !codeHigh && lowMaskOk
                          && (acceptAnyAck || sentMatch);

  wire [31:0] rxCodeSet = intrHit ? codeHot : 32'h00000000;
  wire [31:0] ackExtSet = (extHit || ackHit) ? codeHot : 32'h00000000;

  // a handled ack retires the watchdog of its number
  // extended codes have no ack, so the upper half never cancels
  assign ackClear = {32'h00000000, (ackHit ? codeHot : 32'h00000000)};

  // expiry is filtered by the mask of its bank at the moment it fires
  // a mask cleared mid-wait swallows that expiry for good
  wire [31:0] tmoLowSet  = expireVec[31:0] & acceptMaskLow_q;
  wire [31:0] tmoHighSet = expireVec[63:32] & acceptMaskHigh_q;

  dira_code_timer #(
    .NUM (64),
    .CW  (CW)
  ) u_timer (
    .core_clk      (core_clk),
    .reset         (reset),
    .sendValid     (sentValid),
    .sendNum       (sentNum),
    .ackClear      (ackClear),
    .timeoutPeriod (timeoutPeriodTimer),
    .pendingVec    (pendingVec),
    .expireVec     (expireVec)
  );

  // next flag values; set is applied after clear so a same-cycle event survives
  always @* begin
    receivedCodeBits_d     = receivedCodeBits_q;
    ackOrExtReceivedBits_d = ackOrExtReceivedBits_q;
    codeTimeoutLow_d       = codeTimeoutLow_q;
    codeTimeoutHigh_d      = codeTimeoutHigh_q;
    if (wrAccess && hitRxCode) begin
      receivedCodeBits_d = receivedCodeBits_d & ~regWdata;
    end
    if (wrAccess && hitAckExt) begin
      ackOrExtReceivedBits_d = ackOrExtReceivedBits_d & ~regWdata;
    end
    // the shared timeout offset follows the bank that the mode selects
    if (wrAccess && hitTmo && !extendedModeSelect) begin
      codeTimeoutLow_d = codeTimeoutLow_d & ~regWdata;
    end
    if (wrAccess && hitTmo && extendedModeSelect) begin
      codeTimeoutHigh_d = codeTimeoutHigh_d & ~regWdata;
    end
    receivedCodeBits_d     = receivedCodeBits_d | rxCodeSet;
    ackOrExtReceivedBits_d = ackOrExtReceivedBits_d | ackExtSet;
    codeTimeoutLow_d       = codeTimeoutLow_d | tmoLowSet;
    codeTimeoutHigh_d      = codeTimeoutHigh_d | tmoHighSet;
  end

  // interrupt on every set event, even onto a bit already high
  // one shared pulse; software reads the flags to learn the source
  always @* begin
    irq_d = 1'b0;
    if (rxCodeIrqEnable && (|rxCodeSet)) begin
      irq_d = 1'b1;
    end
    if (rxAckIrqEnable && (|ackExtSet)) begin
      irq_d = 1'b1;
    end
    if (timeoutIrqEnable && portIrqEnable && ((|tmoLowSet) || (|tmoHighSet))) begin
      irq_d = 1'b1;
    end
  end

  // read mux; unmapped offsets read as zero
  // the mode bit picks the bank, so set it before reading the shared offsets
  always @* begin
    rdata_d = 32'h00000000;
    if (hitRxCode) begin
      rdata_d = receivedCodeBits_q;
    end else if (hitAckExt) begin
      rdata_d = ackOrExtReceivedBits_q;
    end else if (hitTmo) begin
      rdata_d = extendedModeSelect ? codeTimeoutHigh_q : codeTimeoutLow_q;
    end else if (hitMask) begin
      rdata_d = extendedModeSelect ? acceptMaskHigh_q : acceptMaskLow_q;
    end
  end

  // flags and masks; everything clears on reset
  // watchdog state stays in the timer; only flags and masks live here
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      receivedCodeBits_q     <= `DIRA_RST_FLAGS;
      ackOrExtReceivedBits_q <= `DIRA_RST_FLAGS;
      codeTimeoutLow_q       <= `DIRA_RST_FLAGS;
      codeTimeoutHigh_q      <= `DIRA_RST_FLAGS;
      acceptMaskLow_q        <= `DIRA_RST_MASK;
      acceptMaskHigh_q       <= `DIRA_RST_MASK;
    end else begin
      receivedCodeBits_q     <= receivedCodeBits_d;
      ackOrExtReceivedBits_q <= ackOrExtReceivedBits_d;
      codeTimeoutLow_q       <= codeTimeoutLow_d;
      codeTimeoutHigh_q      <= codeTimeoutHigh_d;
      // masks share one offset; the mode picks which bank a write reaches
      if (wrAccess && hitMask && !extendedModeSelect) begin
        acceptMaskLow_q <= regWdata;
      end
      if (wrAccess && hitMask && extendedModeSelect) begin
        acceptMaskHigh_q <= regWdata;
      end
    end
  end

  // registered read data, ready and interrupt pulse
  // ready answers every strobe, mapped or not, so the bus never stalls
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      regRdata <= 32'h00000000;
      regReady <= 1'b0;
      irqPulse <= 1'b0;
    end else begin
      regReady <= regSel;
      irqPulse <= irq_d;
      if (rdAccess) begin
        regRdata <= rdata_d;
      end
    end
  end

endmodule // dira_receive
